// [dynamic_clock_switch.sv]
// dynamic clock switch: command decode, source enables, readiness count,
// reset start-up delay, glitch-free source switch and clock output gating
// assumes osc_tick pulses are one clk cycle wide and synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module dynamic_clock_switch import dcs_pkg::*; #(
	parameter int T_4P1 = T_4P1_CYC,
	parameter int T_65  = T_65_CYC,
	parameter int T_4   = T_4_CYC
) (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic            ce,
	input  wire reg_req_t        req,
	output logic [7:0]           rdata,
	input  wire logic [6:0]      low_fuse,
	input  wire logic            reset_pin_disable_fuse,
	input  wire logic [NSRC-1:0] osc_tick,
	input  wire logic            div_clk,
	input  wire logic            tmr_lf_req,
	input  wire logic            tmr_ext_req,
	output logic [NSRC-1:0]      src_en,
	output logic [3:0]           sys_src,
	output logic                 sys_hold,
	output logic                 clock_output_pin,
	output logic                 clock_output_oe,
	output logic                 tmr_lf_gnt,
	output logic                 tmr_ext_gnt
);
	typedef enum {S_LOAD, S_TIME, S_CYC, S_RUN} rst_state_t;

	// source kind of a select code
	function automatic kind_t kind_of(input logic [3:0] c);
		if (c[3])
			kind_of = K_HF;
		else if (c == SRC_LF)
			kind_of = K_LF;
		else if (c == SRC_WD)
			kind_of = K_WD;
		else if (c == SRC_RC)
			kind_of = K_RC;
		else
			kind_of = K_EXT;
	endfunction : kind_of

	// readiness terminal count in source cycles
	function automatic logic [15:0] term_of(input logic [3:0] c, input logic [1:0] u);
		case (kind_of(c))
			K_LF:    term_of = (u == 2'h0 || u == 2'h1) ? TC_1K : TC_32K;
			K_HF: begin
				case ({c[0], u})
					3'h0, 3'h1: term_of = TC_258;
					3'h2, 3'h3, 3'h4: term_of = TC_1K;
					default: term_of = TC_16K;
				endcase
			end
			default: term_of = TC_6;
		endcase
	endfunction : term_of

	// extra time from reset
	function automatic logic [1:0] delay_of(input logic [3:0] c, input logic [1:0] u,
			input logic rd);
		case (kind_of(c))
			K_LF:    delay_of = (u == 2'h0) ? D_4P1 : D_65;
			K_HF: begin
				case ({c[0], u})
					3'h2, 3'h5: delay_of = D_NONE;
					3'h1, 3'h4, 3'h7: delay_of = D_65;
					default: delay_of = D_4P1;
				endcase
			end
			default: delay_of = (u == 2'h0) ? (rd ? D_4 : D_NONE) : (u == 2'h1 ? D_4P1 : D_65);
		endcase
	endfunction : delay_of

	////////////////////////////////////////////////////////////////////////////
	// state
	rst_state_t        st_reg, st_next;
	logic [23:0]       tm_reg, tm_next;
	logic [15:0]       rc_reg, rc_next;
	logic [3:0]        source_select_field_reg, source_select_field_next;
	logic [1:0]        startup_select_field_reg, startup_select_field_next;
	logic              clock_output_bit_reg, clock_output_bit_next;
	logic              cce_reg, cce_next;
	logic [NSRC-1:0]   en_reg, en_next;
	logic [3:0]        sys_reg, sys_next;
	logic              run_reg, run_next;
	logic              rdy_reg, rdy_next;
	logic [15:0]       cnt_reg, cnt_next;
	kind_t             ck_reg, ck_next;
	logic [15:0]       ctc_reg, ctc_next;
	logic              swp_reg, swp_next;
	logic [3:0]        swt_reg, swt_next;
	logic [7:0]        rd_reg;
	logic [NSRC-1:0]   src_en_reg;
	logic              hold_reg, co_reg, coe_reg, lfg_reg, exg_reg;

	////////////////////////////////////////////////////////////////////////////
	// register decode
	wire        wr_cmd  = req.we && req.addr == ADDR_CMD;
	wire        wr_sel  = req.we && req.addr == ADDR_SEL;
	wire        any_wr  = req.we;
	wire        running = st_reg == S_RUN;
	wire [3:0]  code    = req.wdata[3:0];
	wire        accept  = wr_cmd && cce_reg && !req.wdata[CMD_CCE_BIT] && running;
	wire        do_dis  = accept && code == CMD_DISABLE;
	wire        do_en   = accept && code == CMD_ENABLE;
	wire        do_req  = accept && code == CMD_REQUEST;
	wire        do_sw   = accept && code == CMD_SWITCH;
	wire        do_rec  = accept && code == CMD_RECOVER;
	wire kind_t sel_k   = kind_of(source_select_field_reg);
	wire kind_t sys_k   = kind_of(sys_reg);
	wire kind_t swt_k   = kind_of(swt_reg);
	wire        start   = do_en || do_req;
	wire        tick_c  = osc_tick[ck_reg];
	wire        cnt_end = run_reg && tick_c && cnt_reg + 16'h0001 == ctc_reg;
	wire        sw_done = swp_reg && osc_tick[swt_k];
	wire        hf_on   = en_reg[K_HF];
	wire        lf_on   = en_reg[K_LF];
	wire        lf_gnt  = tmr_lf_req && (!hf_on || !en_reg[K_EXT]);
	wire        ext_gnt = tmr_ext_req && !hf_on && !lf_on;
	wire        no_xtal = sys_k != K_HF && sys_k != K_LF;
	wire        co_want = (!low_fuse[SEL_CLOCK_OUTPUT_BIT_BIT] || clock_output_bit_reg) && no_xtal && running;
	wire [1:0]  dsel    = delay_of(low_fuse[3:0], low_fuse[5:4], reset_pin_disable_fuse);
	wire [15:0] rtc     = kind_of(low_fuse[3:0]) == K_LF
		? term_of(low_fuse[3:0], low_fuse[5:4]) : TC_14;
	wire [7:0]  rd_cmd  = {cce_reg, 2'h0, rdy_reg, 4'h0};
	wire [7:0]  rd_sel  = {1'b0, clock_output_bit_reg, startup_select_field_reg, source_select_field_reg};
	wire [7:0]  rd_mux  = req.addr == ADDR_CMD ? rd_cmd
		: (req.addr == ADDR_SEL ? rd_sel : 8'h00);

	////////////////////////////////////////////////////////////////////////////
	// reset start-up sequencer and fuse copy
	always_comb begin
		st_next = st_reg;
		tm_next = tm_reg;
		rc_next = rc_reg;
		case (st_reg)
			S_LOAD: begin
				st_next = S_TIME;
				case (dsel)
					D_4P1:   tm_next = 24'(T_4P1);
					D_65:    tm_next = 24'(T_65);
					D_4:     tm_next = 24'(T_4);
					default: tm_next = 24'h000000;
				endcase
				rc_next = rtc;
			end
			S_TIME: begin
				if (tm_reg == 24'h000000)
					st_next = S_CYC;
				else
					tm_next = tm_reg - 24'h000001;
			end
			S_CYC: begin
				if (rc_reg == 16'h0000)
					st_next = S_RUN;
				else if (osc_tick[sys_k])
					rc_next = rc_reg - 16'h0001;
			end
			S_RUN: st_next = S_RUN;
			default: st_next = S_LOAD;
		endcase
	end

	// selection register, enables and switch
	always_comb begin
		source_select_field_next = source_select_field_reg;
		startup_select_field_next = startup_select_field_reg;
		clock_output_bit_next = clock_output_bit_reg;
		en_next = en_reg;
		sys_next = sys_reg;
		swp_next = swp_reg;
		swt_next = swt_reg;
		if (st_reg == S_LOAD) begin
			source_select_field_next = low_fuse[3:0];
			startup_select_field_next = low_fuse[5:4];
			clock_output_bit_next = !low_fuse[SEL_CLOCK_OUTPUT_BIT_BIT];
			sys_next = low_fuse[3:0];
			en_next = '0;
			en_next[kind_of(low_fuse[3:0])] = 1'b1;
		end else if (do_rec) begin
			source_select_field_next = sys_reg;
		end else if (wr_sel) begin
			source_select_field_next = req.wdata[3:0];
			startup_select_field_next = req.wdata[5:4];
			clock_output_bit_next = req.wdata[SEL_CLOCK_OUTPUT_BIT_BIT];
		end
		if (do_en)
			en_next[sel_k] = 1'b1;
		if (do_dis && sel_k != sys_k)
			en_next[sel_k] = 1'b0;
		if (do_sw && en_reg[sel_k]) begin
			swp_next = 1'b1;
			swt_next = source_select_field_reg;
		end
		if (sw_done) begin
			sys_next = swt_reg;
			swp_next = 1'b0;
		end
	end

	// change enable window and readiness count
	always_comb begin
		cce_next = cce_reg;
		if (any_wr)
			cce_next = wr_cmd && req.wdata[CMD_CCE_BIT];
		run_next = run_reg;
		rdy_next = rdy_reg;
		cnt_next = cnt_reg;
		ck_next = ck_reg;
		ctc_next = ctc_reg;
		if (start) begin
			run_next = 1'b1;
			rdy_next = 1'b0;
			cnt_next = 16'h0000;
			ck_next = sel_k;
			ctc_next = term_of(source_select_field_reg, startup_select_field_reg);
		end else if (cnt_end) begin
			run_next = 1'b0;
			rdy_next = 1'b1;
		end else if (run_reg && tick_c) begin
			cnt_next = cnt_reg + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// flip-flops
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= S_LOAD;
			tm_reg <= 24'h000000;
			rc_reg <= 16'h0000;
			{clock_output_bit_reg, startup_select_field_reg, source_select_field_reg} <= SEL_RESET;
			en_reg <= '0;
			sys_reg <= 4'h0;
			swp_reg <= 1'b0;
			swt_reg <= 4'h0;
			cce_reg <= 1'b0;
			run_reg <= 1'b0;
			rdy_reg <= 1'b0;
			cnt_reg <= 16'h0000;
			ck_reg <= K_EXT;
			ctc_reg <= 16'h0000;
		end else if (ce) begin
			st_reg <= st_next;
			tm_reg <= tm_next;
			rc_reg <= rc_next;
			source_select_field_reg <= source_select_field_next;
			startup_select_field_reg <= startup_select_field_next;
			clock_output_bit_reg <= clock_output_bit_next;
			en_reg <= en_next;
			sys_reg <= sys_next;
			swp_reg <= swp_next;
			swt_reg <= swt_next;
			cce_reg <= cce_next;
			run_reg <= run_next;
			rdy_reg <= rdy_next;
			cnt_reg <= cnt_next;
			ck_reg <= ck_next;
			ctc_reg <= ctc_next;
		end
	end

	// registered outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_reg <= 8'h00;
			src_en_reg <= '0;
			hold_reg <= 1'b1;
			co_reg <= 1'b0;
			coe_reg <= 1'b0;
			lfg_reg <= 1'b0;
			exg_reg <= 1'b0;
		end else if (ce) begin
			rd_reg <= req.re ? rd_mux : 8'h00;
			src_en_reg <= en_reg | {1'b0, lf_gnt, 2'b00, ext_gnt};
			hold_reg <= !running;
			co_reg <= co_want && div_clk;
			coe_reg <= co_want;
			lfg_reg <= lf_gnt;
			exg_reg <= ext_gnt;
		end
	end

	assign rdata = rd_reg;
	assign src_en = src_en_reg;
	assign sys_src = sys_reg;
	assign sys_hold = hold_reg;
	assign clock_output_pin = co_reg;
	assign clock_output_oe = coe_reg;
	assign tmr_lf_gnt = lfg_reg;
	assign tmr_ext_gnt = exg_reg;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	cmd_gate_a: assert property (ce && wr_cmd && !cce_reg |=> $stable(en_reg) && !$rose(run_reg))
		else $error("command taken without change enable");
	cce_once_a: assert property (ce && any_wr && cce_reg |=> !cce_reg || $past(req.wdata[7]))
		else $error("change enable outlived next write");
	one_action_a: assert property ($onehot0({do_dis, do_en, do_req, do_sw, do_rec}))
		else $error("more than one action decoded");
	rdy_clear_a: assert property (ce && start |=> !rdy_reg && run_reg)
		else $error("ready not cleared at count start");
	rdy_hold_a: assert property (ce && rdy_reg && !start |=> rdy_reg)
		else $error("ready flag dropped without new count");
	rdy_set_a: assert property (ce && cnt_end && !start |=> rdy_reg && !run_reg)
		else $error("ready not set at terminal count");
	enable_latch_a: assert property (ce && do_en |=> en_reg[$past(sel_k)])
		else $error("enable command did not latch source");
	dis_guard_a: assert property (ce && do_dis && sel_k == sys_k |=> $stable(en_reg))
		else $error("running system source was disabled");
	recover_val_a: assert property (ce && do_rec |=> source_select_field_reg == $past(sys_reg)
		&& $stable(startup_select_field_reg) && $stable(clock_output_bit_reg))
		else $error("recover wrote wrong code");
	fuse_copy_a: assert property (ce && st_reg == S_LOAD |=> source_select_field_reg == $past(low_fuse[3:0])
		&& clock_output_bit_reg == !$past(low_fuse[6]))
		else $error("fuse copy mismatch");
	clkout_hold_a: assert property (clock_output_oe |-> $past(running))
		else $error("clock output driven during reset");
	lf_grant_a: assert property (ce && tmr_lf_req && hf_on && en_reg[K_EXT] |=> !tmr_lf_gnt)
		else $error("timer grant while sources busy");
	ext_grant_a: assert property (ce && tmr_ext_req && !hf_on && !lf_on |=> tmr_ext_gnt)
		else $error("external clock grant missing");

	switch_c: cover property (ce && sw_done);
	ready_c: cover property (ce && cnt_end);
	recover_c: cover property (ce && do_rec);
	boot_c: cover property (st_reg == S_CYC ##1 st_reg == S_RUN);
endmodule : dynamic_clock_switch
`default_nettype wire

// [dcs_pkg.sv]
// constants, field layouts and carriers of the dynamic clock switch
// assumes a 200 MHz register clock and synchronous oscillator tick inputs
`default_nettype none
package dcs_pkg;
	// register addresses on the plain port
	localparam logic [1:0] ADDR_CMD = 2'h0;
	localparam logic [1:0] ADDR_SEL = 2'h1;
	// command register layout
	localparam int CMD_CCE_BIT = 7;
	localparam int CMD_RDY_BIT = 4;
	localparam logic [3:0] CMD_DISABLE = 4'h1;
	localparam logic [3:0] CMD_ENABLE  = 4'h2;
	localparam logic [3:0] CMD_REQUEST = 4'h3;
	localparam logic [3:0] CMD_SWITCH  = 4'h4;
	localparam logic [3:0] CMD_RECOVER = 4'h5;
	localparam logic [3:0] CMD_WD_ARL  = 4'h6;
	// selection register and fuse byte layout (same positions)
	localparam int SEL_SOURCE_SELECT_FIELD_LO = 0;
	localparam int SEL_STARTUP_SELECT_FIELD_LO = 4;
	localparam int SEL_CLOCK_OUTPUT_BIT_BIT = 6;
	localparam logic [6:0] SEL_RESET = 7'h00;
	// source codes of the source select field
	localparam logic [3:0] SRC_EXT = 4'h0;
	localparam logic [3:0] SRC_RC  = 4'h2;
	localparam logic [3:0] SRC_WD  = 4'h3;
	localparam logic [3:0] SRC_LF  = 4'h6;
	// source kinds, index into the enable vector
	localparam int NSRC = 5;
	localparam logic [2:0] K_EXT = 3'h0;
	localparam logic [2:0] K_RC  = 3'h1;
	localparam logic [2:0] K_WD  = 3'h2;
	localparam logic [2:0] K_LF  = 3'h3;
	localparam logic [2:0] K_HF  = 3'h4;
	// start-up cycle counts in source cycles
	localparam logic [15:0] TC_6   = 16'h0006;
	localparam logic [15:0] TC_14  = 16'h000e;
	localparam logic [15:0] TC_258 = 16'h0102;
	localparam logic [15:0] TC_1K  = 16'h0400;
	localparam logic [15:0] TC_16K = 16'h4000;
	localparam logic [15:0] TC_32K = 16'h8000;
	// reset delay times in microseconds, converted at the clock rate
	localparam int CLK_MHZ = 200;
	localparam int T_4P1_US = 4100;
	localparam int T_65_US = 65000;
	localparam int T_4_US = 4000;
	localparam int T_4P1_CYC = T_4P1_US * CLK_MHZ;
	localparam int T_65_CYC = T_65_US * CLK_MHZ;
	localparam int T_4_CYC = T_4_US * CLK_MHZ;
	// delay selector for the reset timer
	localparam logic [1:0] D_NONE = 2'h0;
	localparam logic [1:0] D_4P1  = 2'h1;
	localparam logic [1:0] D_65   = 2'h2;
	localparam logic [1:0] D_4    = 2'h3;
	// register port request
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} reg_req_t;
	typedef logic [2:0] kind_t;
endpackage : dcs_pkg
`default_nettype wire

// [osc_model.sv]
// oscillator model: one tick pulse per source cycle while that source is on
// assumes src_en from the clock switch; each source period in clk cycles
`timescale 1ns/1ps
`default_nettype none
module osc_model import dcs_pkg::*; #(
	parameter logic [39:0] PER = 40'h0502040103
) (
	input  wire logic            clk,
	input  wire logic [NSRC-1:0] src_en,
	output logic [NSRC-1:0]      osc_tick
);
	////////////////////////////////////////////////////////////////////////
	// per-source cycle counter, held at zero while the source is off
	for (genvar i = 0; i < NSRC; i++) begin : g_src
		logic [7:0] cnt_reg;
		wire  [7:0] last = PER[i*8 +: 8] - 8'h01;
		always_ff @(posedge clk) begin
			if (!src_en[i] || cnt_reg == last) cnt_reg <= 8'h00;
			else cnt_reg <= cnt_reg + 8'h01;
		end
		// a stopped oscillator gives no ticks at all
		assign osc_tick[i] = src_en[i] && (cnt_reg == last);
	end
endmodule : osc_model
`default_nettype wire

// [dynamic_clock_switch_bench.sv]
// self-checking bench of the dynamic clock switch with oscillator model
// assumes short reset delays (20, 40, 10 cycles) and fixed seed 73
`timescale 1ns/1ps
`default_nettype none
module dynamic_clock_switch_bench;
	import dcs_pkg::*;
	localparam int T4P1 = 20;
	localparam int T65 = 40;
	localparam int T4 = 10;
	localparam logic [39:0] PER = 40'h0502040103;
	logic            clk = 1'b0;
	logic            rst = 1'b1;
	logic            div_clk = 1'b0;
	logic            tmr_lf_req = 1'b0;
	logic            tmr_ext_req = 1'b0;
	logic            rpd = 1'b0;
	logic            ce = 1'b1;
	logic [6:0]      low_fuse = 7'h02;
	reg_req_t        req = '0;
	logic [7:0]      rdata;
	logic [NSRC-1:0] osc_tick;
	logic [NSRC-1:0] src_en;
	logic [3:0]      sys_src;
	logic            sys_hold;
	logic            pin;
	logic            oe;
	logic            lf_gnt;
	logic            ext_gnt;
	int              mismatches = 0;
	int              n_checks = 0;
	int              cyc = 0;
	logic [6:0]      fz [4] = '{7'h00, 7'h10, 7'h16, 7'h02};
	logic            rp [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
	////////////////////////////////////////////////////////////////////////
	// clock, divided clock stand-in and hang guard
	always #2.5 clk = ~clk;
	always @(posedge clk) div_clk <= ~div_clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	dynamic_clock_switch #(.T_4P1(T4P1), .T_65(T65), .T_4(T4)) uut (
		.clk(clk), .rst(rst), .ce(ce), .req(req), .rdata(rdata),
		.low_fuse(low_fuse), .reset_pin_disable_fuse(rpd), .osc_tick(osc_tick),
		.div_clk(div_clk), .tmr_lf_req(tmr_lf_req), .tmr_ext_req(tmr_ext_req),
		.src_en(src_en), .sys_src(sys_src), .sys_hold(sys_hold),
		.clock_output_pin(pin), .clock_output_oe(oe),
		.tmr_lf_gnt(lf_gnt), .tmr_ext_gnt(ext_gnt));
	osc_model #(.PER(PER)) osc (.clk(clk), .src_en(src_en), .osc_tick(osc_tick));
	////////////////////////////////////////////////////////////////////////
	// bus tasks, comparison and expectation helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) req <= '0;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) req <= '0;
		#1 d = rdata;
	endtask : rd
	task automatic cmd(input logic [3:0] c);
		wr(ADDR_CMD, 8'h80);
		wr(ADDR_CMD, {4'h0, c});
	endtask : cmd
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_cyc
	task automatic wait_rdy(output int n);
		logic [7:0] d;
		n = 0;
		d = 8'h00;
		while (d[CMD_RDY_BIT] !== 1'b1 && n < 8000) begin
			rd(ADDR_CMD, d);
			n += 2;
		end
	endtask : wait_rdy
	function automatic int hold_exp(input logic [6:0] f, input logic r);
		int t;
		int n;
		int p;
		p = (f[3:0] == SRC_LF) ? 2 : (f[3:0] == SRC_EXT) ? 3 : 1;
		n = (f[3:0] != SRC_LF) ? 14 : (f[5:4] < 2'h2) ? 1024 : 32768;
		case (f[5:4])
			2'h0: t = (f[3:0] == SRC_LF) ? T4P1 : (r ? T4 : 0);
			2'h1: t = (f[3:0] == SRC_LF) ? T65 : T4P1;
			default: t = T65;
		endcase
		return t + n * p;
	endfunction : hold_exp
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [7:0] d;
		logic [7:0] v;
		logic       dv;
		int         n;
		int         e;
		void'($urandom(73));
		// reset per fuse setting, start-up hold length and fuse copy
		for (int k = 0; k < 4; k++) begin
			@(posedge clk) rst <= 1'b1;
			low_fuse <= fz[k];
			rpd <= rp[k];
			wait_cyc(6);
			check({6'h0, oe, sys_hold}, 8'h01);
			@(posedge clk) rst <= 1'b0;
			rd(ADDR_SEL, d);
			check(d, {1'b0, ~fz[k][6], fz[k][5:0]});
			n = 2;
			while (sys_hold !== 1'b0 && n < 5000) begin
				@(posedge clk) #1;
				n++;
			end
			e = hold_exp(fz[k], rp[k]);
			check({7'h0, n >= e && n <= e + 6}, 8'h01);
		end
		$display("test reset delays done");
		// register access at random, unmapped places, clock output pin
		for (int i = 0; i < 16; i++) begin
			v = 8'($urandom) & 8'h7f;
			wr(ADDR_SEL, v);
			rd(ADDR_SEL, d);
			check(d, v);
			wr(2'h3, 8'($urandom));
		end
		rd(2'h2, d);
		check(d, 8'h00);
		wr(ADDR_SEL, 8'h02);
		check({7'h0, oe}, 8'h01);
		for (int i = 0; i < 4; i++) begin
			#1 dv = div_clk;
			@(posedge clk) #1 check({7'h0, pin}, {7'h0, dv});
		end
		tmr_ext_req <= 1'b1;
		wait_cyc(4);
		check({6'h0, ext_gnt, src_en[K_EXT]}, 8'h03);
		tmr_ext_req <= 1'b0;
		$display("test registers and output done");
		// unprotected and interrupted commands are refused
		wr(ADDR_SEL, 8'h46);
		wr(ADDR_CMD, {4'h0, CMD_ENABLE});
		wr(ADDR_CMD, 8'h80);
		wr(ADDR_SEL, 8'h46);
		wr(ADDR_CMD, {4'h0, CMD_ENABLE});
		wait_cyc(4);
		check({7'h0, src_en[K_LF]}, 8'h00);
		// enable starts the count, both sources stay on
		cmd(CMD_ENABLE);
		rd(ADDR_CMD, d);
		check({7'h0, d[CMD_RDY_BIT]}, 8'h00);
		check({6'h0, src_en[K_LF], src_en[K_RC]}, 8'h03);
		tmr_lf_req <= 1'b1;
		tmr_ext_req <= 1'b1;
		wait_cyc(4);
		check({6'h0, lf_gnt, ext_gnt}, 8'h02);
		tmr_lf_req <= 1'b0;
		tmr_ext_req <= 1'b0;
		wait_rdy(n);
		check({7'h0, n >= 1023 * 2 - 6 && n <= 1024 * 2 + 10}, 8'h01);
		cmd(CMD_REQUEST);
		rd(ADDR_CMD, d);
		check({7'h0, d[CMD_RDY_BIT]}, 8'h00);
		wait_rdy(n);
		check({7'h0, n >= 1023 * 2 - 6 && n <= 1024 * 2 + 10}, 8'h01);
		$display("test enable and readiness done");
		// switch, recover, disable of current and old source
		cmd(CMD_SWITCH);
		n = 0;
		while (sys_src !== SRC_LF && n < 20) begin
			@(posedge clk);
			n++;
		end
		check({4'h0, sys_src}, {4'h0, SRC_LF});
		wait_cyc(3);
		check({7'h0, oe}, 8'h00);
		wr(ADDR_SEL, 8'h32);
		cmd(CMD_RECOVER);
		rd(ADDR_SEL, d);
		check(d, 8'h36);
		cmd(CMD_DISABLE);
		wait_cyc(3);
		check({7'h0, src_en[K_LF]}, 8'h01);
		v = {3'h0, src_en};
		cmd(CMD_WD_ARL);
		wait_cyc(3);
		check({3'h0, src_en}, v);
		wr(ADDR_SEL, 8'h02);
		cmd(CMD_DISABLE);
		wait_cyc(3);
		check({6'h0, src_en[K_LF], src_en[K_RC]}, 8'h02);
		$display("test switch and disable done");
		// both crystals busy: timer grants refused, several sources on
		wr(ADDR_SEL, 8'h00);
		cmd(CMD_ENABLE);
		wait_rdy(n);
		check({7'h0, n >= 6 * 3 - 6 && n <= 6 * 3 + 10}, 8'h01);
		wr(ADDR_SEL, 8'h08);
		cmd(CMD_ENABLE);
		wait_rdy(n);
		check({7'h0, n >= 258 * 5 - 6 && n <= 258 * 5 + 10}, 8'h01);
		check({6'h0, src_en[K_HF], src_en[K_EXT]}, 8'h03);
		tmr_lf_req <= 1'b1;
		tmr_ext_req <= 1'b1;
		wait_cyc(4);
		check({6'h0, lf_gnt, ext_gnt}, 8'h00);
		tmr_lf_req <= 1'b0;
		tmr_ext_req <= 1'b0;
		// clock enable low freezes the selection register
		@(posedge clk) ce <= 1'b0;
		wr(ADDR_SEL, 8'h46);
		ce <= 1'b1;
		rd(ADDR_SEL, d);
		check(d, 8'h08);
		$display("test grants and freeze done");
		tally_and_finish();
	end
endmodule : dynamic_clock_switch_bench
`default_nettype wire
